// *** sid_pkg.sv ***
// Package: descriptor field layout, codes and states for the split interrupt descriptor engine
package sid_pkg;
    // Descriptor word widths
    localparam int DESC_W = 64;

    // DW0 fields
    localparam int V_BIT      = 0;
    localparam int XFER_LSB   = 3;
    localparam int XFER_W     = 15;

    // DW1 fields
    localparam int TOKEN_LSB  = 42;
    localparam int CLASS_LSB  = 44;
    localparam int SPLIT_BIT  = 46;
    localparam int SPEED_LSB  = 48;
    localparam int PORT_LSB   = 50;
    localparam int HUB_LSB    = 57;
    localparam int ID7_W      = 7;

    // DW2 fields
    localparam int POLL_LSB   = 3;
    localparam int POLL_W     = 5;
    localparam int START_LSB  = 8;
    localparam int START_W    = 16;

    // DW3 fields
    localparam int COUNT_LSB  = 32;
    localparam int COUNT_W    = 12;
    localparam int RETRY_LSB  = 55;
    localparam int TOGGLE_BIT = 57;
    localparam int PHASE_BIT  = 59;
    localparam int XERR_BIT   = 60;
    localparam int BABBLE_BIT = 61;
    localparam int HALT_BIT   = 62;
    localparam int ACTIVE_BIT = 63;

    // Token, speed and retry codes
    localparam logic [1:0] TOKEN_OUT  = 2'h0;
    localparam logic [1:0] TOKEN_IN   = 2'h1;
    localparam logic [1:0] SPEED_LOW  = 2'h2;
    localparam logic [1:0] SPEED_FULL = 2'h0;
    localparam logic [1:0] RETRY_NONE = 2'h0;

    // Polling exponent bounds; 4 means every frame of 8 microframes
    localparam logic [4:0] POLL_B_MIN = 5'h04;
    localparam logic [4:0] POLL_B_MAX = 5'h10;

    // Interrupt status bit positions
    localparam int IRQ_DONE  = 0;
    localparam int IRQ_HALT  = 1;
    localparam int IRQ_ERR   = 2;
    localparam int IRQ_W     = 3;

    // Register offsets (word addresses on the plain port)
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_MASK   = 4'h1;
    localparam logic [3:0] REG_STATE  = 4'h2;
    localparam logic [3:0] REG_COUNT  = 4'h3;
    localparam logic [3:0] REG_MFRAME = 4'h4;

    typedef enum logic [2:0] {
        SID_IDLE,
        SID_WAIT,
        SID_ISSUE,
        SID_RESULT,
        SID_WRBACK
    } sid_state_t;
endpackage

// *** sid_poll_timer.sv ***
// Polling interval timer: fires once every 2^(b-1) microframes
`timescale 1ns/10ps
`default_nettype none
module sid_poll_timer
    import sid_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        restart,
    input  wire logic        uframe_tick,
    input  wire logic [4:0]  poll_b,
    output logic             due
);
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic [15:0] period_m1;
    logic [4:0]  b_clamp;
    logic        wrap;

    // Out-of-range exponents are clamped so a bad field never stalls polling
    assign b_clamp   = (poll_b < POLL_B_MIN) ? POLL_B_MIN :
                       (poll_b > POLL_B_MAX) ? POLL_B_MAX : poll_b;
    assign period_m1 = 16'((17'h1 << (b_clamp - 5'h01)) - 17'h1);
    assign wrap      = uframe_tick && (cnt_ff >= period_m1);
    assign nxt_cnt   = restart ? 16'h0000 :
                       wrap ? 16'h0000 :
                       uframe_tick ? cnt_ff + 16'h0001 : cnt_ff;
    assign due       = wrap;

    // Microframe counter
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= 16'h0000;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule
`default_nettype wire

// *** sid_engine.sv ***
// Split interrupt descriptor engine: decodes, schedules and writes back one descriptor
//
// Functional notes
// - Software loads the toggle before activation; hardware flips it per good transaction.
// - Retry budget 00 means no retry, 11 three; decremented on each error.
// - Bytes actually moved are written back into the transferred count field.
// - Payload start is an internal buffer memory address, not a processor address.
// - Polling interval is 2^(b-1) microframes for b from 4 to 16.
// - Exponent 4 runs the descriptor once in every frame.
// - Hub address field targets the hub for split tokens.
// - Port field gives the downstream hub or translator port for splits.
// - Speed code is honoured only for start and complete splits.
// - Split select: 0 plain high-speed, 1 split through a translator.
// - Token code 00 issues OUT, 01 issues IN.
// - Speed code 10 marks low speed, 00 marks full speed.
// - Hardware clears valid when done or on fatal error.
// - Halt flag set when any transfer status reports stall or halt.
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module sid_engine
    import sid_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 arst_n,
    // Descriptor load and write back
    input  wire logic                 desc_load,
    input  wire logic [DESC_W-1:0]    desc_dw0,
    input  wire logic [DESC_W-1:0]    desc_dw1,
    input  wire logic [DESC_W-1:0]    desc_dw2,
    input  wire logic [DESC_W-1:0]    desc_dw3,
    output logic [DESC_W-1:0]         wb_dw0,
    output logic [DESC_W-1:0]         wb_dw3,
    output logic                      wb_valid,
    // Microframe timing
    input  wire logic                 uframe_tick,
    // Transaction request to the link engine
    output logic                      txn_req,
    output logic [1:0]                txn_token,
    output logic                      txn_split,
    output logic                      txn_complete,
    output logic                      txn_low_speed,
    output logic [ID7_W-1:0]          txn_hub_id,
    output logic [ID7_W-1:0]          txn_hub_port,
    output logic                      txn_toggle,
    output logic [START_W-1:0]        txn_buf_addr,
    output logic [COUNT_W-1:0]        txn_len,
    // Transaction result from the link engine
    input  wire logic                 res_valid,
    input  wire logic                 res_ok,
    input  wire logic                 res_err,
    input  wire logic                 res_babble,
    input  wire logic                 res_stall,
    input  wire logic [COUNT_W-1:0]   res_bytes,
    // Register port
    input  wire logic [3:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [31:0]               reg_rdata,
    output logic                      irq
);
    sid_state_t            state_ff;
    sid_state_t            nxt_state;
    logic [DESC_W-1:0]     dw0_ff;
    logic [DESC_W-1:0]     dw1_ff;
    logic [DESC_W-1:0]     dw2_ff;
    logic [DESC_W-1:0]     dw3_ff;
    logic [DESC_W-1:0]     nxt_dw0;
    logic [DESC_W-1:0]     nxt_dw3;
    logic                  hold_uf_ff;
    logic                  wb_valid_ff;
    logic [IRQ_W-1:0]      status_ff;
    logic [IRQ_W-1:0]      mask_ff;
    logic [31:0]           rdata_ff;
    logic [31:0]           nxt_rdata;
    logic [IRQ_W-1:0]      ev;
    logic [IRQ_W-1:0]      w1c;

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    logic                  f_valid;
    logic                  f_split;
    logic [1:0]            f_token;
    logic [1:0]            f_speed;
    logic [ID7_W-1:0]      f_hub;
    logic [ID7_W-1:0]      f_port;
    logic [START_W-1:0]    f_start;
    logic [POLL_W-1:0]     f_poll;
    logic [1:0]            f_retry;
    logic                  f_toggle;
    logic                  f_phase;
    logic                  f_active;
    logic [XFER_W-1:0]     f_xfer;

    assign f_valid  = dw0_ff[V_BIT];
    assign f_xfer   = dw0_ff[XFER_LSB +: XFER_W];
    assign f_token  = dw1_ff[TOKEN_LSB +: 2];
    assign f_split  = dw1_ff[SPLIT_BIT];
    assign f_speed  = dw1_ff[SPEED_LSB +: 2];
    assign f_port   = dw1_ff[PORT_LSB +: ID7_W];
    assign f_hub    = dw1_ff[HUB_LSB +: ID7_W];
    assign f_poll   = dw2_ff[POLL_LSB +: POLL_W];
    assign f_start  = dw2_ff[START_LSB +: START_W];
    assign f_retry  = dw3_ff[RETRY_LSB +: 2];
    assign f_toggle = dw3_ff[TOGGLE_BIT];
    assign f_phase  = dw3_ff[PHASE_BIT];
    assign f_active = dw3_ff[ACTIVE_BIT];

    // ------------------------------------------------------------
    // Polling schedule
    // ------------------------------------------------------------
    logic poll_due;
    logic poll_restart;

    assign poll_restart = desc_load;

    sid_poll_timer u_poll (
        .core_clk    (core_clk),
        .arst_n      (arst_n),
        .restart     (poll_restart),
        .uframe_tick (uframe_tick),
        .poll_b      (f_poll),
        .due         (poll_due)
    );

    // ------------------------------------------------------------
    // Transaction request outputs
    // ------------------------------------------------------------
    // Unknown token codes are never issued; the descriptor is retired instead
    logic tok_legal;
    logic can_run;

    assign tok_legal     = (f_token == TOKEN_OUT) || (f_token == TOKEN_IN);
    assign can_run       = f_valid && f_active;
    assign txn_req       = (state_ff == SID_ISSUE);
    assign txn_token     = f_token;
    assign txn_split     = f_split;
    assign txn_complete  = f_split && f_phase;
    // Speed only matters on splits; plain high-speed ignores it
    assign txn_low_speed = f_split && (f_speed == SPEED_LOW);
    assign txn_hub_id    = f_split ? f_hub : 7'h00;
    assign txn_hub_port  = f_split ? f_port : 7'h00;
    assign txn_toggle    = f_toggle;
    assign txn_buf_addr  = f_start;
    assign txn_len       = (f_xfer > XFER_W'(4095)) ? 12'hfff : f_xfer[COUNT_W-1:0];

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            SID_IDLE: begin
                if (can_run) begin
                    nxt_state = SID_WAIT;
                end
            end
            SID_WAIT: begin
                // Complete split waits for the microframe after next, start split for its slot
                if (!can_run) begin
                    nxt_state = SID_IDLE;
                end else if (!tok_legal) begin
                    nxt_state = SID_WRBACK;
                end else if (txn_complete ? (uframe_tick && !hold_uf_ff) : poll_due) begin
                    nxt_state = SID_ISSUE;
                end
            end
            SID_ISSUE: begin
                nxt_state = SID_RESULT;
            end
            SID_RESULT: begin
                if (res_valid) begin
                    nxt_state = SID_WRBACK;
                end
            end
            SID_WRBACK: begin
                nxt_state = (nxt_dw0[V_BIT] && nxt_dw3[ACTIVE_BIT]) ? SID_WAIT : SID_IDLE;
            end
        endcase
    end

    // Result merge into the descriptor images
    always_comb begin
        nxt_dw0 = dw0_ff;
        nxt_dw3 = dw3_ff;
        if (state_ff == SID_WAIT && can_run && !tok_legal) begin
            nxt_dw0[V_BIT]      = 1'b0;
            nxt_dw3[ACTIVE_BIT] = 1'b0;
        end else if (state_ff == SID_RESULT && res_valid) begin
            nxt_dw3[COUNT_LSB +: COUNT_W] = res_bytes;
            nxt_dw3[BABBLE_BIT] = dw3_ff[BABBLE_BIT] | res_babble;
            if (res_stall) begin
                nxt_dw3[HALT_BIT]   = 1'b1;
                nxt_dw3[ACTIVE_BIT] = 1'b0;
                nxt_dw0[V_BIT]      = 1'b0;
            end else if (res_err) begin
                if (f_retry == RETRY_NONE) begin
                    nxt_dw3[XERR_BIT]   = 1'b1;
                    nxt_dw3[ACTIVE_BIT] = 1'b0;
                    nxt_dw0[V_BIT]      = 1'b0;
                end else begin
                    nxt_dw3[RETRY_LSB +: 2] = f_retry - 2'h1;
                end
            end else if (res_ok) begin
                if (f_split && !f_phase) begin
                    nxt_dw3[PHASE_BIT] = 1'b1;
                end else begin
                    nxt_dw3[TOGGLE_BIT] = ~f_toggle;
                    nxt_dw3[PHASE_BIT]  = 1'b0;
                    nxt_dw3[ACTIVE_BIT] = 1'b0;
                    nxt_dw0[V_BIT]      = 1'b0;
                end
            end
        end
    end

    // State and descriptor registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= SID_IDLE;
            dw0_ff   <= '0;
            dw1_ff   <= '0;
            dw2_ff   <= '0;
            dw3_ff   <= '0;
        end else if (desc_load) begin
            state_ff <= SID_IDLE;
            dw0_ff   <= desc_dw0;
            dw1_ff   <= desc_dw1;
            dw2_ff   <= desc_dw2;
            dw3_ff   <= desc_dw3;
        end else begin
            state_ff <= nxt_state;
            dw0_ff   <= nxt_dw0;
            dw3_ff   <= nxt_dw3;
        end
    end

    // Marks the microframe of a start split so its complete goes later
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_uf_ff <= 1'b0;
        end else if (state_ff == SID_ISSUE) begin
            hold_uf_ff <= 1'b1;
        end else if (uframe_tick) begin
            hold_uf_ff <= 1'b0;
        end
    end

    // Write-back strobe one cycle after the merge
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_valid_ff <= 1'b0;
        end else begin
            wb_valid_ff <= (state_ff == SID_WRBACK);
        end
    end

    assign wb_valid = wb_valid_ff;
    assign wb_dw0   = dw0_ff;
    assign wb_dw3   = dw3_ff;

    // ------------------------------------------------------------
    // Interrupt status and register port
    // ------------------------------------------------------------
    logic done_ev;
    logic wr_status;
    logic wr_mask;

    assign done_ev   = (state_ff == SID_WRBACK) && !(nxt_dw0[V_BIT]);
    assign ev[IRQ_DONE] = done_ev;
    assign ev[IRQ_HALT] = (state_ff == SID_RESULT) && res_valid && res_stall;
    assign ev[IRQ_ERR]  = (state_ff == SID_RESULT) && res_valid && res_err;
    assign wr_status = reg_wr && (reg_addr == REG_STATUS);
    assign wr_mask   = reg_wr && (reg_addr == REG_MASK);
    assign w1c       = wr_status ? reg_wdata[IRQ_W-1:0] : '0;
    assign irq       = |(status_ff & mask_ff);

    // Set wins over a same-cycle clear so no event is lost
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_ff <= '0;
            mask_ff   <= '0;
        end else begin
            status_ff <= (status_ff & ~w1c) | ev;
            if (wr_mask) begin
                mask_ff <= reg_wdata[IRQ_W-1:0];
            end
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        unique case (reg_addr)
            REG_STATUS: nxt_rdata = {29'h0, status_ff};
            REG_MASK:   nxt_rdata = {29'h0, mask_ff};
            REG_STATE:  nxt_rdata = {24'h0, 1'b0, 3'(state_ff), f_phase,
                                     f_toggle, f_retry};
            REG_COUNT:  nxt_rdata = {20'h0, dw3_ff[COUNT_LSB +: COUNT_W]};
            REG_MFRAME: nxt_rdata = {27'h0, f_poll};
            default:    nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= reg_rd ? nxt_rdata : 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_ff;
endmodule
`default_nettype wire

// *** sid_engine_properties.sv ***
// Checker: port-level properties of the descriptor engine
`timescale 1ns/10ps
`default_nettype none
module sid_engine_properties
    import sid_pkg::*;
(
    input wire logic               core_clk,
    input wire logic               arst_n,
    input wire logic               desc_load,
    input wire logic [DESC_W-1:0]  desc_dw1,
    input wire logic [DESC_W-1:0]  desc_dw2,
    input wire logic [DESC_W-1:0]  wb_dw0,
    input wire logic [DESC_W-1:0]  wb_dw3,
    input wire logic               wb_valid,
    input wire logic [1:0]         txn_token,
    input wire logic               txn_split,
    input wire logic               txn_low_speed,
    input wire logic [ID7_W-1:0]   txn_hub_id,
    input wire logic [ID7_W-1:0]   txn_hub_port,
    input wire logic [START_W-1:0] txn_buf_addr,
    input wire logic               res_valid,
    input wire logic               res_err,
    input wire logic               res_stall,
    input wire logic [COUNT_W-1:0] res_bytes
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Result flags only mean something beside res_valid
    wire err_v   = res_valid & res_err;
    wire stall_v = res_valid & res_stall;
    property p_buf;
        desc_load |=> txn_buf_addr == $past(desc_dw2[START_LSB+:START_W]);
    endproperty
    a_buf: assert property (p_buf) else $error("buffer start wrong");
    property p_hub;
        desc_load && desc_dw1[SPLIT_BIT] |=> txn_hub_id == $past(desc_dw1[HUB_LSB+:ID7_W])
            && txn_hub_port == $past(desc_dw1[PORT_LSB+:ID7_W]);
    endproperty
    a_hub: assert property (p_hub) else $error("hub target wrong");
    property p_split;
        desc_load |=> txn_split == $past(desc_dw1[SPLIT_BIT]) && (txn_split || txn_hub_id == 0);
    endproperty
    a_split: assert property (p_split) else $error("split select wrong");
    property p_token;
        desc_load |=> txn_token == $past(desc_dw1[TOKEN_LSB+:2]);
    endproperty
    a_token: assert property (p_token) else $error("token wrong");
    property p_low;
        desc_load |=> txn_low_speed
            == $past(desc_dw1[SPLIT_BIT] && desc_dw1[SPEED_LSB+:2] == SPEED_LOW);
    endproperty
    a_low: assert property (p_low) else $error("speed code wrong");
    property p_count;
        wb_valid && $past(res_valid, 2) |-> wb_dw3[COUNT_LSB+:COUNT_W] == $past(res_bytes, 2);
    endproperty
    a_count: assert property (p_count) else $error("byte count wrong");
    property p_stall;
        wb_valid && $past(stall_v, 2) |-> wb_dw3[HALT_BIT] && !wb_dw3[ACTIVE_BIT] && !wb_dw0[V_BIT];
    endproperty
    a_stall: assert property (p_stall) else $error("stall not retired");
    property p_err;
        wb_valid && $past(err_v, 2) && $past(wb_dw3[RETRY_LSB+:2], 2) == RETRY_NONE
            |-> wb_dw3[XERR_BIT] && !wb_dw3[ACTIVE_BIT]
            && wb_dw3[RETRY_LSB+:2] == RETRY_NONE;
    endproperty
    a_err: assert property (p_err) else $error("error not retired");
    // Main scenarios reached
    c_stall: cover property (wb_valid && $past(stall_v, 2));
    c_err: cover property (wb_valid && $past(err_v, 2));
    c_split: cover property (desc_load && desc_dw1[SPLIT_BIT]);
endmodule
`default_nettype wire

// *** sid_link_model.sv ***
// Partner model: translator and endpoint answering each request
`timescale 1ns/10ps
`default_nettype none
module sid_link_model
    import sid_pkg::*;
(
    input wire logic               core_clk,
    input wire logic               arst_n,
    input wire logic               txn_req,
    input wire logic [1:0]         mode,
    input wire logic [3:0]         delay,
    input wire logic [COUNT_W-1:0] bytes,
    output logic                   res_valid,
    output logic                   res_ok,
    output logic                   res_err,
    output logic                   res_babble,
    output logic                   res_stall,
    output logic [COUNT_W-1:0]     res_bytes
);
    // ----------------------------------------
    // Answer logic
    // ----------------------------------------
    logic       pend_ff;
    logic [3:0] wait_ff;
    // Idle lines flip each cycle so stale flags never pass for an answer
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            {pend_ff, wait_ff, res_valid, res_ok, res_err, res_babble, res_stall, res_bytes} <= '0;
        end else begin
            res_valid <= 1'b0;
            {res_ok, res_err, res_babble, res_stall} <= ~{res_ok, res_err, res_babble, res_stall};
            res_bytes <= ~res_bytes;
            if (txn_req) begin
                pend_ff <= 1'b1;
                wait_ff <= delay;
            end else if (pend_ff && wait_ff != 4'h0) begin
                wait_ff <= wait_ff - 4'h1;
            end else if (pend_ff) begin
                pend_ff <= 1'b0;
                res_valid <= 1'b1;
                res_ok <= mode == 2'h0;
                res_err <= mode == 2'h1;
                res_stall <= mode == 2'h2;
                res_babble <= 1'b0;
                res_bytes <= bytes;
            end
        end
    end
endmodule
`default_nettype wire

// *** test_split_interrupt_descriptor.sv ***
// Testbench: descriptor runs, results, register port and interrupt
`timescale 1ns/10ps
`default_nettype none
module test_split_interrupt_descriptor;
    import sid_pkg::*;
    // ----------------------------------------
    // Stimulus and checks
    // ----------------------------------------
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic desc_load = 1'b0;
    logic [DESC_W-1:0] desc_dw0 = '0, desc_dw1 = '0, desc_dw2 = '0, desc_dw3 = '0;
    logic uframe_tick = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = '0, delay = 4'h2;
    logic [31:0] reg_wdata = '0, reg_rdata, rd;
    logic [1:0] mode = '0, tc = '0, txn_token;
    logic [COUNT_W-1:0] bytes = '0, txn_len, res_bytes;
    logic [DESC_W-1:0] wb_dw0, wb_dw3;
    logic wb_valid, txn_req, txn_split, txn_complete, txn_low_speed, txn_toggle, irq;
    logic [ID7_W-1:0] txn_hub_id, txn_hub_port;
    logic [START_W-1:0] txn_buf_addr;
    logic res_valid, res_ok, res_err, res_babble, res_stall;
    int failures = 0, check_count = 0, ticks = 0;
    sid_engine i_dut (.core_clk, .arst_n, .desc_load, .desc_dw0, .desc_dw1, .desc_dw2,
        .desc_dw3, .wb_dw0, .wb_dw3, .wb_valid, .uframe_tick, .txn_req, .txn_token,
        .txn_split, .txn_complete, .txn_low_speed, .txn_hub_id, .txn_hub_port,
        .txn_toggle, .txn_buf_addr, .txn_len, .res_valid, .res_ok, .res_err,
        .res_babble, .res_stall, .res_bytes, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .irq);
    sid_link_model i_link (.core_clk, .arst_n, .txn_req, .mode, .delay, .bytes,
        .res_valid, .res_ok, .res_err, .res_babble, .res_stall, .res_bytes);
    always #4 core_clk = ~core_clk;
    // Microframe every 4 cycles; ticks counts them since the last load
    always @(posedge core_clk) begin
        tc <= tc + 2'h1;
        uframe_tick <= tc == 2'h3;
        ticks <= desc_load ? 0 : ticks + int'(uframe_tick);
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic reg_wr32(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic reg_rd32(input logic [3:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask
    // Hub 15, port 0a, class interrupt, buffer 1234, 40 bytes; active and valid set
    task automatic load(input logic s, input logic [1:0] sp, input logic [1:0] tk,
                        input logic [4:0] b, input logic tg, input logic [1:0] ry);
        @(posedge core_clk);
        desc_load <= 1'b1;
        desc_dw0 <= 64'h1 | (64'h40 << XFER_LSB);
        desc_dw1 <= {7'h15, 7'h0a, sp, 1'b0, s, 2'h3, tk, 42'h0};
        desc_dw2 <= {40'h0, 16'h1234, b, 3'h0};
        desc_dw3 <= {1'b1, 5'h0, tg, ry, 55'h0};
        @(posedge core_clk);
        desc_load <= 1'b0;
        #1;
    endtask
    // Bounded wait for a one-cycle pulse: request (0) or write back (1)
    task automatic wait_on(input logic sel);
        #1;
        for (int i = 0; i < 300 && (sel ? wb_valid : txn_req) !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
        check(sel ? wb_valid : txn_req, 1'b1);
    endtask
    task automatic run(input logic [1:0] m, input logic [COUNT_W-1:0] by);
        @(posedge core_clk);
        mode <= m;
        bytes <= by;
        wait_on(1'b0);
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        // Plain OUT at exponent 4, good answer
        load(1'b0, SPEED_LOW, TOKEN_OUT, 5'h4, 1'b0, RETRY_NONE);
        run(2'h0, 12'h02a);
        check(ticks, 8);
        check({txn_split, txn_low_speed, txn_hub_id}, 9'h0);
        check(txn_token, TOKEN_OUT);
        check(txn_buf_addr, 16'h1234);
        check({txn_toggle, txn_len}, 13'h0040);
        wait_on(1'b1);
        check(wb_dw3[COUNT_LSB+:COUNT_W], 12'h02a);
        check(wb_dw3[TOGGLE_BIT], 1'b1);
        check({wb_dw3[ACTIVE_BIT], wb_dw0[V_BIT]}, 2'h0);
        reg_rd32(REG_COUNT);
        check(rd, 32'h2a);
        reg_rd32(REG_MFRAME);
        check(rd, 32'h4);
        // Unmapped read, then mask, raise and clear the interrupt
        reg_rd32(4'hf);
        check(rd, 32'h0);
        check(irq, 1'b0);
        reg_wr32(REG_MASK, 32'h7);
        reg_rd32(REG_STATUS);
        check(rd[IRQ_DONE], 1'b1);
        check(irq, 1'b1);
        reg_wr32(REG_STATUS, 32'h7);
        reg_rd32(REG_STATUS);
        check({irq, rd}, 33'h0);
        // Speed codes: split low, split full, plain with low code; reloads abort
        for (int i = 0; i < 3; i++) begin
            load(i != 2, i == 1 ? SPEED_FULL : SPEED_LOW, TOKEN_IN, 5'h4, 1'b0, RETRY_NONE);
            check(txn_low_speed, i == 0);
            check(txn_hub_id, i != 2 ? 7'h15 : 7'h0);
        end
        // Low-speed IN split at exponent 5: start, then complete
        load(1'b1, SPEED_LOW, TOKEN_IN, 5'h5, 1'b1, RETRY_NONE);
        run(2'h0, 12'h000);
        check(ticks, 16);
        check({txn_complete, txn_low_speed, txn_hub_port, txn_token}, 11'h229);
        run(2'h0, 12'h008);
        check(txn_complete, 1'b1);
        wait_on(1'b1);
        check({wb_dw3[TOGGLE_BIT], wb_dw3[PHASE_BIT]}, 2'h0);
        check(wb_dw3[COUNT_LSB+:COUNT_W], 12'h008);
        // One retry allowed: second error retires with the error flag
        load(1'b0, SPEED_FULL, TOKEN_IN, 5'h4, 1'b0, 2'h1);
        run(2'h1, 12'h000);
        run(2'h1, 12'h000);
        wait_on(1'b1);
        check({wb_dw3[XERR_BIT], wb_dw3[RETRY_LSB+:2], wb_dw3[ACTIVE_BIT]}, 4'h8);
        // Stall halts and retires at once despite retries left
        load(1'b0, SPEED_FULL, TOKEN_IN, 5'h4, 1'b0, 2'h3);
        run(2'h2, 12'h000);
        wait_on(1'b1);
        check({wb_dw3[HALT_BIT], wb_dw3[ACTIVE_BIT], wb_dw0[V_BIT]}, 3'h4);
        reg_rd32(REG_STATUS);
        check(rd[IRQ_HALT], 1'b1);
        report_and_stop();
    end
    // Watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (8000) @(posedge core_clk);
        failures++;
        report_and_stop();
    end
endmodule
bind sid_engine sid_engine_properties i_props (.core_clk, .arst_n, .desc_load, .desc_dw1,
    .desc_dw2, .wb_dw0, .wb_dw3, .wb_valid, .txn_token, .txn_split, .txn_low_speed,
    .txn_hub_id, .txn_hub_port, .txn_buf_addr, .res_valid, .res_err, .res_stall, .res_bytes);
`default_nettype wire
